// *** verilog/bidir_reset_defines.svh ***
// named offsets, field positions, reset values and timing counts of the reset controller
`ifndef BIDIR_RESET_DEFINES_SVH
`define BIDIR_RESET_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_SYSTEM_CONFIG  4'h0
`define OFS_RESET_FLAGS    4'h4
`define OFS_IRQ_STATUS     4'h8
`define OFS_IRQ_MASK       4'hC

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_BIDIR_ENABLE   0
`define BIT_BOOT_SELECT    4
`define FLAG_HW_LONG       0
`define FLAG_HW_SHORT      1
`define FLAG_SW            2
`define FLAG_WDT           3
`define EVT_HW             0
`define EVT_SW             1
`define EVT_WDT            2
`define EVT_END_OF_INIT_INSTR          3

// ----------------------------------------------------------------
// widths, reset values and timing
// ----------------------------------------------------------------
`define ADDR_W             4
`define DATA_W             32
`define BOOT_W             16
`define CNT_W              16
`define NIBBLE_W           4
`define NIBBLE_ZERO        4'h0
`define CNT_ZERO           16'h0000
`define CNT_ONE            16'h0001
`define BOOT_RESET         16'h0000
`define DATA_ZERO          32'h0000_0000
`define SEQ_CYCLES_DEFAULT 1024
`define SETTLE_CYCLES      16'h0003

`endif

// *** verilog/bidir_reset_pkg.sv ***
// types shared by the bidirectional reset controller
`include "bidir_reset_defines.svh"

package bidir_reset_pkg;

  typedef enum logic [3:0] {
    ST_RUN    = 4'b0001,
    ST_SEQ    = 4'b0010,
    ST_PIN    = 4'b0100,
    ST_SETTLE = 4'b1000
  } rst_state_e;

  typedef struct packed {
    logic                   read;
    logic                   write;
    logic [`ADDR_W-1:0]     address;
    logic [`DATA_W-1:0]     writedata;
    logic [`NIBBLE_W-1:0]   byteenable;
  } avmm_req_s;

  typedef struct packed {
    logic [`DATA_W-1:0]     readdata;
    logic                   waitrequest;
  } avmm_rsp_s;

  typedef struct packed {
    rst_state_e             state;
    logic [`CNT_W-1:0]      cnt;
    logic                   pin_s1;
    logic                   pin_s2;
    logic [`BOOT_W-1:0]     boot_s1;
    logic [`BOOT_W-1:0]     boot_s2;
    logic [`BOOT_W-1:0]     boot_cfg;
    logic                   enable;
    logic                   bidir_act;
    logic                   init_done;
    logic                   rst_ind_n;
    logic                   src_hw;
    logic [`NIBBLE_W-1:0]   flags;
    logic [`NIBBLE_W-1:0]   status;
    logic [`NIBBLE_W-1:0]   mask;
    logic                   ack;
    logic [`DATA_W-1:0]     rdata;
  } ctl_state_s;

endpackage

// *** verilog/bidirectional_reset_control.sv ***
// reset sequencer with optional bidirectional reset pin and avalon-mm registers
//
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "bidir_reset_defines.svh"

module bidirectional_reset_control
#(
  parameter int SEQ_CYCLES = `SEQ_CYCLES_DEFAULT
)
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire bidir_reset_pkg::avmm_req_s   avs_req,
  output var  bidir_reset_pkg::avmm_rsp_s   avs_rsp,
  input  wire logic                         reset_in_pin_i,
  output logic                              reset_in_pin_o,
  output logic                              reset_in_pin_oe,
  input  wire logic                         sw_reset_req,
  input  wire logic                         wdt_reset_req,
  input  wire logic                         end_of_init_instr,
  input  wire logic [`BOOT_W-1:0]           boot_config_port,
  output logic [`BOOT_W-1:0]                boot_config_latched,
  output logic                              boot_loader_start,
  output logic                              core_reset,
  output logic                              reset_indication_out_n,
  output logic                              irq
);
  import bidir_reset_pkg::*;

  if (SEQ_CYCLES < 2 || SEQ_CYCLES >= (1 << `CNT_W))
  begin : g_seq_range
    $error("SEQ_CYCLES out of range for the sequence counter");
  end

  localparam logic [`CNT_W-1:0] SEQ_LAST = `CNT_W'(SEQ_CYCLES - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  ctl_state_s cur_reg;
  ctl_state_s cur_next;

  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic lane0;
  logic pin_low;
  logic [`NIBBLE_W-1:0] evt;

  assign bus_req  = avs_req.read | avs_req.write;
  assign bus_take = bus_req & cur_reg.ack;
  assign wr_take  = avs_req.write & bus_take;
  assign lane0    = avs_req.byteenable[0];
  // the pin reads low while we drive it ourselves; ignore it then
  assign pin_low  = ~cur_reg.pin_s2;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cur_next = cur_reg;
    evt      = `NIBBLE_ZERO;

    cur_next.pin_s1  = reset_in_pin_i;
    cur_next.pin_s2  = cur_reg.pin_s1;
    cur_next.boot_s1 = boot_config_port;
    cur_next.boot_s2 = cur_reg.boot_s1;

    unique case (cur_reg.state)
      ST_RUN:
      begin
        if (pin_low || sw_reset_req || wdt_reset_req)
        begin
          cur_next.state     = ST_SEQ;
          cur_next.cnt       = `CNT_ZERO;
          cur_next.bidir_act = cur_reg.enable;
          cur_next.enable    = 1'b0;
          cur_next.init_done = 1'b0;
          cur_next.rst_ind_n = 1'b0;
          cur_next.src_hw    = pin_low;
          cur_next.flags     = `NIBBLE_ZERO;
          if (pin_low)
          begin
            cur_next.flags[`FLAG_HW_SHORT] = 1'b1;
            evt[`EVT_HW] = 1'b1;
          end
          else if (sw_reset_req)
          begin
            cur_next.flags[`FLAG_SW] = 1'b1;
            evt[`EVT_SW] = 1'b1;
          end
          else
          begin
            cur_next.flags[`FLAG_WDT] = 1'b1;
            evt[`EVT_WDT] = 1'b1;
          end
        end
        else if (end_of_init_instr && !cur_reg.init_done)
        begin
          cur_next.init_done = 1'b1;
          cur_next.rst_ind_n = 1'b1;
          evt[`EVT_END_OF_INIT_INSTR] = 1'b1;
        end
      end
      ST_SEQ:
      begin
        cur_next.cnt = cur_reg.cnt + `CNT_ONE;
        if (cur_reg.cnt == SEQ_LAST)
        begin
          cur_next.cnt = `CNT_ZERO;
          if (cur_reg.bidir_act)
          begin
            // the pin was ours, so any outside pulse is already stretched
            cur_next.flags = `NIBBLE_ZERO;
            cur_next.flags[`FLAG_HW_LONG] = 1'b1;
            cur_next.boot_cfg = cur_reg.boot_s2;
            cur_next.state    = ST_SETTLE;
          end
          else if (cur_reg.src_hw && pin_low)
          begin
            cur_next.flags = `NIBBLE_ZERO;
            cur_next.flags[`FLAG_HW_LONG] = 1'b1;
            cur_next.state = ST_PIN;
          end
          else
          begin
            if (cur_reg.src_hw)
              cur_next.boot_cfg = cur_reg.boot_s2;
            cur_next.state = ST_SETTLE;
          end
        end
      end
      ST_PIN:
      begin
        if (!pin_low)
        begin
          cur_next.boot_cfg = cur_reg.boot_s2;
          cur_next.state    = ST_SETTLE;
        end
      end
      ST_SETTLE:
      begin
        // lets the released pin pass the synchroniser before it is watched again
        cur_next.cnt = cur_reg.cnt + `CNT_ONE;
        if (cur_reg.cnt == `SETTLE_CYCLES)
        begin
          cur_next.cnt   = `CNT_ZERO;
          cur_next.state = ST_RUN;
        end
      end
    endcase

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    cur_next.ack = bus_req & ~cur_reg.ack;
    if (bus_req && !cur_reg.ack)
    begin
      cur_next.rdata = `DATA_ZERO;
      if (hit(avs_req.address, `OFS_SYSTEM_CONFIG))
        cur_next.rdata[`BIT_BIDIR_ENABLE] = cur_reg.enable;
      else if (hit(avs_req.address, `OFS_RESET_FLAGS))
        cur_next.rdata[`NIBBLE_W-1:0] = cur_reg.flags;
      else if (hit(avs_req.address, `OFS_IRQ_STATUS))
        cur_next.rdata[`NIBBLE_W-1:0] = cur_reg.status;
      else if (hit(avs_req.address, `OFS_IRQ_MASK))
        cur_next.rdata[`NIBBLE_W-1:0] = cur_reg.mask;
    end

    if (wr_take && lane0 && hit(avs_req.address, `OFS_SYSTEM_CONFIG)
        // a reset starting in this cycle must still clear the bit
        && !cur_reg.init_done && cur_reg.state == ST_RUN && cur_next.state == ST_RUN)
      cur_next.enable = avs_req.writedata[`BIT_BIDIR_ENABLE];
    if (wr_take && lane0 && hit(avs_req.address, `OFS_IRQ_MASK))
      cur_next.mask = avs_req.writedata[`NIBBLE_W-1:0];

    // set wins over a simultaneous write-one-to-clear
    if (wr_take && lane0 && hit(avs_req.address, `OFS_IRQ_STATUS))
      cur_next.status = cur_reg.status & ~avs_req.writedata[`NIBBLE_W-1:0];
    cur_next.status = cur_next.status | evt;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cur_reg.state     <= ST_RUN;
      cur_reg.cnt       <= `CNT_ZERO;
      cur_reg.pin_s1    <= 1'b1;
      cur_reg.pin_s2    <= 1'b1;
      cur_reg.boot_s1   <= `BOOT_RESET;
      cur_reg.boot_s2   <= `BOOT_RESET;
      cur_reg.boot_cfg  <= `BOOT_RESET;
      cur_reg.enable    <= 1'b0;
      cur_reg.bidir_act <= 1'b0;
      cur_reg.init_done <= 1'b0;
      cur_reg.rst_ind_n <= 1'b0;
      cur_reg.src_hw    <= 1'b0;
      cur_reg.flags     <= `NIBBLE_ZERO;
      cur_reg.status    <= `NIBBLE_ZERO;
      cur_reg.mask      <= `NIBBLE_ZERO;
      cur_reg.ack       <= 1'b0;
      cur_reg.rdata     <= `DATA_ZERO;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // open-drain: only ever drives low, outside drivers must be open-drain too
  assign reset_in_pin_o  = 1'b0;
  assign reset_in_pin_oe = cur_reg.bidir_act & (cur_reg.state == ST_SEQ);
  assign core_reset      = (cur_reg.state != ST_RUN);
  assign reset_indication_out_n = cur_reg.rst_ind_n;
  assign boot_config_latched    = cur_reg.boot_cfg;
  assign boot_loader_start      = ~cur_reg.boot_cfg[`BIT_BOOT_SELECT];
  assign irq                    = |(cur_reg.status & cur_reg.mask);
  assign avs_rsp.waitrequest    = bus_req & ~cur_reg.ack;
  assign avs_rsp.readdata       = cur_reg.rdata;

endmodule

`default_nettype wire

// *** testbench/bidir_reset_properties.sv ***
// port-level checks of the reset controller
`timescale 1ns/1ns
`default_nettype none
`include "bidir_reset_defines.svh"

module bidir_reset_properties
#(
  parameter int SEQ_CYCLES = 8
)
(
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire bidir_reset_pkg::avmm_req_s avs_req,
  input wire bidir_reset_pkg::avmm_rsp_s avs_rsp,
  input wire logic                       reset_in_pin_o,
  input wire logic                       reset_in_pin_oe,
  input wire logic                       sw_reset_req,
  input wire logic                       wdt_reset_req,
  input wire logic                       end_of_init_instr,
  input wire logic [`BOOT_W-1:0]         boot_config_latched,
  input wire logic                       boot_loader_start,
  input wire logic                       core_reset,
  input wire logic                       reset_indication_out_n
);
  import bidir_reset_pkg::*;

  logic [15:0] oe_len;
  logic [15:0] core_len;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // run lengths of the pin drive and of the core reset
  always_ff @(posedge sys_clk)
  begin
    oe_len   <= reset_in_pin_oe ? oe_len + 16'h0001 : 16'h0000;
    core_len <= core_reset ? core_len + 16'h0001 : 16'h0000;
  end

  a_wait_single: assert property ((avs_req.read || avs_req.write) && avs_rsp.waitrequest
    |=> !avs_rsp.waitrequest) else $error("waitrequest too long");
  a_pin_drain: assert property (reset_in_pin_oe |-> !reset_in_pin_o && core_reset)
    else $error("pin driven outside sequence");
  a_oe_length: assert property ($fell(reset_in_pin_oe) |-> int'(oe_len) == SEQ_CYCLES)
    else $error("pin drive length wrong");
  a_core_stretch: assert property ($fell(core_reset) |-> int'(core_len) >= SEQ_CYCLES)
    else $error("reset too short");
  a_ind_low: assert property (core_reset |-> !reset_indication_out_n)
    else $error("indication high in reset");
  a_ind_hold: assert property (!reset_indication_out_n && !end_of_init_instr
    |=> !reset_indication_out_n) else $error("indication rose early");
  a_ind_cause: assert property ($rose(reset_indication_out_n) |-> $past(end_of_init_instr))
    else $error("indication rose without end of init");
  a_boot_start: assert property (boot_loader_start == !boot_config_latched[`BIT_BOOT_SELECT])
    else $error("boot loader start wrong");
  a_req_take: assert property (!core_reset && (sw_reset_req || wdt_reset_req)
    |=> core_reset) else $error("reset request not taken");
endmodule

bind bidirectional_reset_control bidir_reset_properties #(.SEQ_CYCLES(SEQ_CYCLES)) u_props
(
  .sys_clk, .rst, .avs_req, .avs_rsp, .reset_in_pin_o, .reset_in_pin_oe, .sw_reset_req,
  .wdt_reset_req, .end_of_init_instr, .boot_config_latched, .boot_loader_start, .core_reset,
  .reset_indication_out_n
);
`default_nettype wire

// *** testbench/reset_source_model.sv ***
// open-drain external reset source on the reset pin
`timescale 1ns/1ns
`default_nettype none

module reset_source_model
(
  input  wire logic sys_clk,
  input  wire logic pull_req,
  output logic      pull_low
);
  // only ever pulls low; released line falls back to the pull-up
  always_ff @(posedge sys_clk)
    pull_low <= pull_req;
endmodule
`default_nettype wire

// *** testbench/bidirectional_reset_control_test.sv ***
// self-checking bench for the bidirectional reset controller
`timescale 1ns/1ns
`default_nettype none

module bidirectional_reset_control_test;
  import bidir_reset_pkg::*;
  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  avmm_req_s   req      = '0;
  avmm_rsp_s   rsp;
  logic        pull_req = 1'b0;
  logic        sw       = 1'b0;
  logic        wdt      = 1'b0;
  logic        eoi      = 1'b0;
  logic [15:0] port     = 16'h0000;
  logic [15:0] seed     = 16'h0045;
  logic [15:0] boot_exp = 16'h0000;
  logic        pin, oe, od, pull_low, boot_go, core, ind_n, irq;
  logic [15:0] latched;
  logic [31:0] q;
  int          b, s;
  int          err_total = 0;
  int          samples_checked = 0;
  int          core_run = 0;
  localparam int SEQ = 8;

  // released pin floats to the pull-up level
  assign pin = !((oe && !od) || pull_low);

  reset_source_model src (.sys_clk(sys_clk), .pull_req(pull_req), .pull_low(pull_low));
  bidirectional_reset_control #(.SEQ_CYCLES(SEQ)) dut
  (
    .sys_clk(sys_clk), .rst(rst), .avs_req(req), .avs_rsp(rsp), .reset_in_pin_i(pin),
    .reset_in_pin_o(od), .reset_in_pin_oe(oe), .sw_reset_req(sw), .wdt_reset_req(wdt),
    .end_of_init_instr(eoi), .boot_config_port(port), .boot_config_latched(latched),
    .boot_loader_start(boot_go), .core_reset(core), .reset_indication_out_n(ind_n), .irq(irq)
  );

  initial forever #20 sys_clk = ~sys_clk;

  // length of the current core reset run, in clock edges
  always @(posedge sys_clk)
    core_run <= (core === 1'b1) ? core_run + 1 : 0;

  // ----
  // helpers
  // ----
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction

  // bidir reports long hw; otherwise one-hot by source
  function automatic logic [3:0] flags_exp(input int bi, input int so);
    return (bi != 0) ? 4'h1 : 4'h2 << so;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      err_total++;
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    // hold the request until waitrequest is sampled low at a rising edge
    do
      @(posedge sys_clk);
    while (rsp.waitrequest !== 1'b0);
    r = rsp.readdata;
    req <= '0;
  endtask

  task automatic wait_core(input logic bi, input int len);
    int n;
    n = 0;
    do @(negedge sys_clk); while (core !== 1'b1 && ++n < 40);
    chk(core, 1'b1);
    chk(oe, bi);
    n = 0;
    do @(negedge sys_clk); while (core !== 1'b0 && ++n < 100);
    chk(core_run, len);
  endtask

  task automatic stop_test;
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    bus(1'b0, 4'hC, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b1, 4'hC, 32'h0000_000F, q);
    // every source with and without bidirectional mode
    for (int k = 0; k < 6; k++)
    begin
      b = k % 2;
      s = k / 2;
      seed = lfsr(seed);
      @(posedge sys_clk);
      port <= seed;
      if (b != 0 || s == 0)
        boot_exp = seed;
      if (b != 0)
        bus(1'b1, 4'h0, 32'h0000_0001, q);
      @(posedge sys_clk);
      pull_req <= (s == 0);
      sw <= (s == 1);
      wdt <= (s == 2);
      @(posedge sys_clk);
      sw <= 1'b0;
      wdt <= 1'b0;
      repeat (2) @(posedge sys_clk);
      pull_req <= 1'b0;
      wait_core(b != 0, SEQ + 4);
      bus(1'b0, 4'h0, 32'h0000_0000, q);
      chk(q, 32'h0000_0000);
      bus(1'b0, 4'h4, 32'h0000_0000, q);
      chk(q, flags_exp(b, s));
      chk(latched, boot_exp);
      chk(boot_go, !boot_exp[4]);
      chk(ind_n, 1'b0);
      chk(irq, 1'b1);
      bus(1'b0, 4'h8, 32'h0000_0000, q);
      chk(q, 4'h1 << s);
      bus(1'b1, 4'h8, q, q);
      @(negedge sys_clk);
      chk(irq, 1'b0);
    end
    // long pin pulse without bidirectional mode: pin held past the sequence
    @(posedge sys_clk);
    pull_req <= 1'b1;
    repeat (20) @(posedge sys_clk);
    pull_req <= 1'b0;
    wait_core(1'b0, 24);
    bus(1'b0, 4'h4, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    chk(latched, boot_exp);
    bus(1'b0, 4'h8, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    bus(1'b1, 4'h8, q, q);
    // lock after end of init
    bus(1'b1, 4'h0, 32'h0000_0001, q);
    bus(1'b0, 4'h0, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    eoi <= 1'b1;
    @(posedge sys_clk);
    eoi <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk(ind_n, 1'b1);
    bus(1'b1, 4'h0, 32'h0000_0000, q);
    bus(1'b0, 4'h0, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    bus(1'b0, 4'h2, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    bus(1'b1, 4'hC, 32'h0000_0000, q);
    @(negedge sys_clk);
    chk(irq, 1'b0);
    bus(1'b1, 4'hC, 32'h0000_0008, q);
    @(negedge sys_clk);
    chk(irq, 1'b1);
    stop_test;
  end

  initial
  begin
    repeat (5000) @(posedge sys_clk);
    err_total++;
    stop_test;
  end
endmodule
`default_nettype wire
